// [hw/clock_ratio_pkg.sv]
// shared constants for the core clock ratio and reset entry block
// assumes one 50 MHz clock; strap and reset pins arrive asynchronously
package clock_ratio_pkg;

   localparam int          STRAP_W       = 3;
   localparam int          HALVES_W      = 4;
   localparam int          BURST_W       = 5;
   localparam int          SYNC_STAGES   = 2;
   localparam int          CLK_PERIOD_NS = 20;

   // ratio strap codes
   localparam logic [2:0]  CODE_X2       = 3'h0;
   localparam logic [2:0]  CODE_X2P5     = 3'h1;
   localparam logic [2:0]  CODE_X3       = 3'h2;
   localparam logic [2:0]  CODE_X3P5     = 3'h3;
   localparam logic [2:0]  CODE_X4       = 3'h4;
   localparam logic [2:0]  CODE_X5       = 3'h5;
   localparam logic [2:0]  CODE_X6       = 3'h6;
   localparam logic [2:0]  CODE_RESERVED = 3'h7;
   localparam logic [2:0]  CODE_DEFAULT  = CODE_X2;

   // multiplier counted in half steps, so 2.5 becomes 5
   localparam logic [3:0]  HALVES_X2     = 4'h4;
   localparam logic [3:0]  HALVES_X2P5   = 4'h5;
   localparam logic [3:0]  HALVES_X3     = 4'h6;
   localparam logic [3:0]  HALVES_X3P5   = 4'h7;
   localparam logic [3:0]  HALVES_X4     = 4'h8;
   localparam logic [3:0]  HALVES_X5     = 4'hA;
   localparam logic [3:0]  HALVES_X6     = 4'hC;

   // values after reset
   localparam logic [2:0]  RST_CODE      = CODE_DEFAULT;
   localparam logic [3:0]  RST_HALVES    = HALVES_X2;
   localparam logic [4:0]  RST_BURST     = 5'h00;

   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_IDLE  = 3'b010,
      ST_RUN   = 3'b100
   } core_state_t;

   // strap code to multiplier in half steps; reserved falls back to default
   function automatic logic [3:0] code_to_halves(input logic [2:0] code);
      logic [3:0] h;
      h = HALVES_X2;
      case (code)
         CODE_X2P5 : h = HALVES_X2P5;
         CODE_X3   : h = HALVES_X3;
         CODE_X3P5 : h = HALVES_X3P5;
         CODE_X4   : h = HALVES_X4;
         CODE_X5   : h = HALVES_X5;
         CODE_X6   : h = HALVES_X6;
         default   : h = HALVES_X2;
      endcase
      return h;
   endfunction

endpackage

// [hw/pin_sync.sv]
// two flip-flop synchroniser for a group of asynchronous pins
// assumes each bit is a level; a multi-bit value is only coherent once stable
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int           W      = 1,
   parameter logic [W-1:0] RST_V  = '0
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] sync
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= RST_V;
         sync <= RST_V;
      end else begin
         meta <= pin;
         sync <= meta;
      end
   end
endmodule
`default_nettype wire

// [hw/core_clock_ratio_strap.sv]
// core clock ratio and reset entry logic
// assumes straps, reset pin and local clock pins are asynchronous board
// levels and that the local clock is slow against clk
`timescale 1ns/1ns
`default_nettype none
module core_clock_ratio_strap
   import clock_ratio_pkg::*;
#(
   parameter int PIN_W = 8
) (
   input  wire logic                           clk,
   input  wire logic                           nrst,
   input  wire logic                           resetPinN,
   input  wire logic                           localClockIn,
   input  wire logic                           localClockRef,
   input  wire logic [clock_ratio_pkg::STRAP_W-1:0] coreRatioStrap,
   input  wire logic                           sysclkFreqStrap,
   input  wire logic                           runRequest,
   input  wire logic [PIN_W-1:0]               driveRequest,
   output logic      [PIN_W-1:0]               pinOutEn,
   output logic      [clock_ratio_pkg::HALVES_W-1:0] ratioHalves,
   output logic      [clock_ratio_pkg::STRAP_W-1:0]  ratioCode,
   output logic                                coreTick,
   output logic                                coreIdle,
   output logic                                inReset,
   output logic                                strapFault
);
   import clock_ratio_pkg::*;

   // synchronised copies of the board pins; nothing below reads a raw pin
   logic                rstSyncN;
   logic                lclkInSync;
   logic                lclkRefSync;
   logic [STRAP_W-1:0]  strapSync;
   logic                freqSync;
   logic                lclkLevelQ;
   logic                halfCarry;
   logic [BURST_W-1:0]  burstLeft;
   core_state_t         state;
   core_state_t         next_state;

   // every asynchronous pin is sampled twice before use
   // the reset pin synchroniser resets to the asserted level, so a release
   // of nrst alone never lets the core run: the pin must be seen high on
   // two edges first; the cost is two cycles of extra reset latency
   // the local clock pair shares one synchroniser so both halves are seen
   // with the same delay; the straps share another for the same reason
   pin_sync #(.W(1), .RST_V(1'b0)) uRstSync (
      .clk  (clk),
      .nrst (nrst),
      .pin  (resetPinN),
      .sync (rstSyncN)
   );
   pin_sync #(.W(2), .RST_V(2'b00)) uClkSync (
      .clk  (clk),
      .nrst (nrst),
      .pin  ({localClockIn, localClockRef}),
      .sync ({lclkInSync, lclkRefSync})
   );
   pin_sync #(.W(STRAP_W + 1), .RST_V({CODE_DEFAULT, 1'b1})) uStrapSync (
      .clk  (clk),
      .nrst (nrst),
      .pin  ({coreRatioStrap, sysclkFreqStrap}),
      .sync ({strapSync, freqSync})
   );

   // decode of sampled levels; kept as named wires so that the clocked
   // processes below stay short and only pick between ready values
   logic                devReset;
   logic                lclkLevel;
   logic                lclkRise;
   logic [HALVES_W-1:0] strapHalves;
   logic [HALVES_W:0]   halfSum;
   logic [BURST_W-1:0]  newBurst;
   logic [BURST_W-1:0]  burstDec;
   logic [BURST_W:0]    burstSum;
   logic                badReserved;
   logic                badFreq;
   logic                strapMoved;

   // device reset comes from the synchronised pin only
   assign devReset    = ~rstSyncN;
   // the pair counts as high only when the pins differ the right way round,
   // so a pair that is shorted together reads as a steady low
   assign lclkLevel   = lclkInSync & ~lclkRefSync;
   // the stored level tracks through reset, so release gives no false edge
   assign lclkRise    = lclkLevel & ~lclkLevelQ;
   // multiplier the strap asks for, in half steps
   assign strapHalves = code_to_halves(strapSync);
   // half steps plus the carried half; bit 0 is the half left over
   assign halfSum     = {1'b0, ratioHalves} + {{HALVES_W{1'b0}}, halfCarry};
   // whole ticks for the burst that starts on this local edge
   assign newBurst    = BURST_W'(halfSum[HALVES_W:1]);
   // ticks still owed, counting down to empty and then staying there
   assign burstDec    = (burstLeft != RST_BURST) ? burstLeft - 5'h01 : RST_BURST;
   // a late burst adds onto the rest of the previous one instead of
   // dropping it; the sum saturates rather than wrapping round
   assign burstSum    = {1'b0, burstDec} + {1'b0, newBurst};
   // straps the board must never present
   assign badReserved = (strapSync == CODE_RESERVED);
   assign badFreq     = ~freqSync;
   // any strap move after capture is a board fault, not a new ratio
   assign strapMoved  = ~devReset & (strapSync != ratioCode);

   // state sequence: reset holds, release lands in idle
   // run is left only through reset; there is no way back to idle from
   // run, which matches a core that starts executing and never parks
   // an illegal code falls back to reset rather than guessing a state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET : if (!devReset) next_state = ST_IDLE;
         ST_IDLE  : if (devReset) next_state = ST_RESET;
                    else if (runRequest) next_state = ST_RUN;
         ST_RUN   : if (devReset) next_state = ST_RESET;
         default  : next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) state <= ST_RESET;
      else       state <= next_state;
   end

   // strap follows the pins only while reset is held, then freezes
   // the last value seen before release wins, so a strap that settles
   // late in reset is still taken; after release a moving strap can no
   // longer disturb the ratio and is only reported through the fault flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ratioCode   <= RST_CODE;
         ratioHalves <= RST_HALVES;
      end else if (devReset) begin
         ratioCode   <= strapSync;
         ratioHalves <= strapHalves;  // reserved code runs at default
      end
   end

   // fault flag for straps the board must keep right; sticky until reset
   // in reset the flag shows the present straps only, so a board fixed
   // during reset comes out clean; outside reset any fault sets it and
   // only the next reset can clear it, so no set is ever lost
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)         strapFault <= 1'b0;
      else if (devReset) strapFault <= badReserved | badFreq;
      else               strapFault <= strapFault | badReserved | badFreq | strapMoved;
   end

   // core tick bursts: n ticks per local period, half steps alternate floor
   // and ceiling so 2.5 gives 2,3,2,3; the burst must finish within one local
   // period, so the local clock has to be at most clk / 6
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lclkLevelQ <= 1'b0;
         halfCarry  <= 1'b0;
         burstLeft  <= RST_BURST;
         coreTick   <= 1'b0;
      end else if (devReset) begin
         lclkLevelQ <= lclkLevel;
         halfCarry  <= 1'b0;
         burstLeft  <= RST_BURST;
         coreTick   <= 1'b0;
      end else begin
         lclkLevelQ <= lclkLevel;
         coreTick   <= (burstLeft != RST_BURST);
         if (lclkRise) begin
            halfCarry <= halfSum[0];
            burstLeft <= burstSum[BURST_W] ? {BURST_W{1'b1}} : burstSum[BURST_W-1:0];
         end else begin
            burstLeft <= burstDec;
         end
      end
   end

   // tick output is a registered copy of the owed count being nonzero, so
   // the first tick of a burst trails the local edge by the sync delay
   // plus two cycles; this latency is fixed and the same for every ratio

   // pin drivers released for the whole reset, so pulls set the levels
   // the enables drop on the edge the next state becomes reset, one cycle
   // after the synchronised pin goes low, and stay low until release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)                   pinOutEn <= '0;
      else if (next_state == ST_RESET) pinOutEn <= '0;
      else                         pinOutEn <= driveRequest;
   end

   // status outputs registered from the next state
   // taking them from the next state keeps them aligned with the state
   // register itself while still coming straight from flip-flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         inReset  <= 1'b1;
         coreIdle <= 1'b1;
      end else begin
         inReset  <= (next_state == ST_RESET);
         coreIdle <= (next_state != ST_RUN);  // execution idle after reset
      end
   end

endmodule
`default_nettype wire

// [bench/core_clock_ratio_strap_monitor.sv]
// checker for the core clock ratio block
// assumes it is bound to the block's top ports
`timescale 1ns/1ns
`default_nettype none
module core_clock_ratio_strap_monitor (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       resetPinN,
   input wire logic [7:0] pinOutEn,
   input wire logic [3:0] ratioHalves,
   input wire logic [2:0] ratioCode,
   input wire logic       coreTick,
   input wire logic       coreIdle,
   input wire logic       inReset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // half steps per code; reserved 7 falls back to x2
   localparam logic [31:0] HTAB = 32'h4CA87654;
   logic [3:0] run;
   // length of the tick burst so far
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) run <= 4'h0;
      else run <= coreTick ? run + 4'h1 : 4'h0;
   end
   AST_OE_RESET: assert property (inReset |-> pinOutEn == 8'h00)
      else $error("enables high in reset");
   AST_IDLE_RESET: assert property (inReset |-> coreIdle && !coreTick)
      else $error("not idle in reset");
   AST_FROZEN: assert property (!inReset && !$past(inReset)
      |-> $stable({ratioCode, ratioHalves})) else $error("ratio moved");
   AST_MAP: assert property (!inReset |-> ratioHalves == HTAB[{ratioCode, 2'b00} +: 4])
      else $error("bad multiplier");
   AST_BURST_MAX: assert property (coreTick |-> run < ((ratioHalves + 4'h1) >> 1))
      else $error("burst too long");
   AST_BURST_MIN: assert property ($fell(coreTick) && !inReset |-> run >= (ratioHalves >> 1))
      else $error("burst too short");
   AST_SYNC: assert property ($rose(resetPinN) && inReset |-> inReset[*3] ##[1:2] !inReset)
      else $error("reset release timing");
endmodule
bind core_clock_ratio_strap core_clock_ratio_strap_monitor mon_u (.clk, .nrst, .resetPinN,
   .pinOutEn, .ratioHalves, .ratioCode, .coreTick, .coreIdle, .inReset);
`default_nettype wire

// [bench/board_model.sv]
// board side: reset source, straps and a free running local clock
// assumes the bench steers it from the clk domain
`timescale 1ns/1ns
`default_nettype none
module board_model (
   input  wire logic clk,
   input  wire logic holdReset,
   input  wire logic [2:0] wantCode,
   input  wire logic freqHigh,
   output logic resetPinN = 1'b0,
   output logic [2:0] coreRatioStrap = 3'h0,
   output logic sysclkFreqStrap = 1'b1,
   output logic localClockIn = 1'b0,
   output logic localClockRef
);
   logic [3:0] phase = 4'h0;
   // straps move only when a scenario asks, otherwise held
   always_ff @(posedge clk) begin
      resetPinN <= !holdReset;
      coreRatioStrap <= wantCode;
      sysclkFreqStrap <= freqHigh;
   end
   // 16 clk local period, slow enough for whole bursts
   always_ff @(posedge clk) begin
      phase <= phase + 4'h1;
      localClockIn <= phase[3];
   end
   assign localClockRef = 1'b0;
endmodule
`default_nettype wire

// [bench/tb_core_clock_ratio_strap.sv]
// bench for the core clock ratio block
// assumes the monitor binds itself and board_model drives the pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb_core_clock_ratio_strap;
   logic clk = 1'b0, nrst = 1'b0, holdReset = 1'b1, freqHigh = 1'b1, runRequest = 1'b0;
   logic [2:0] wantCode = 3'h0, coreRatioStrap, ratioCode;
   logic [7:0] driveRequest = 8'h00, pinOutEn;
   logic [3:0] ratioHalves;
   logic resetPinN, sysclkFreqStrap, localClockIn, localClockRef;
   logic coreTick, coreIdle, inReset, strapFault;
   int error_cnt = 0;
   int n_compared = 0;
   localparam logic [3:0] EXP [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'h4};
   board_model brd_u (.clk, .holdReset, .wantCode, .freqHigh, .resetPinN, .coreRatioStrap,
      .sysclkFreqStrap, .localClockIn, .localClockRef);
   core_clock_ratio_strap dut_u (.clk, .nrst, .resetPinN, .localClockIn, .localClockRef,
      .coreRatioStrap, .sysclkFreqStrap, .runRequest, .driveRequest, .pinOutEn,
      .ratioHalves, .ratioCode, .coreTick, .coreIdle, .inReset, .strapFault);
   initial forever #10 clk = ~clk;
   task automatic tally_and_finish;
      if (error_cnt == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // reset with a strap value, straps settle long before release
   task automatic boot(input logic [2:0] code);
      int i;
      @(posedge clk);
      holdReset <= 1'b1;
      wantCode <= code;
      repeat (6) @(posedge clk);
      holdReset <= 1'b0;
      for (i = 0; i < 20 && inReset !== 1'b0; i++) begin @(posedge clk); #1; end
      `CHK(inReset, 1'b0)
      `CHK(coreIdle, 1'b1)
   endtask
   // every strap code, multiplier and tick count over four local periods
   task automatic t_codes;
      int c;
      logic [7:0] n;
      for (c = 0; c < 8; c++) begin
         @(posedge clk);
         driveRequest <= 8'h5A ^ 8'(c);
         boot(3'(c));
         `CHK(ratioCode, 3'(c))
         `CHK(ratioHalves, EXP[c])
         `CHK(pinOutEn, 8'h5A ^ 8'(c))
         @(posedge localClockIn);
         n = 8'h00;
         repeat (64) begin @(posedge clk); #1 n += {7'h00, coreTick}; end
         `CHK(n, {3'h0, EXP[c], 1'b0})
         `CHK(strapFault, 1'(c == 7))
      end
   endtask
   // run, strap change in run, reset back to idle, low frequency strap
   task automatic t_run;
      boot(3'h3);
      `CHK(strapFault, 1'b0)
      @(posedge clk);
      runRequest <= 1'b1;
      wantCode <= 3'h2;
      repeat (2) @(posedge clk);
      #1 `CHK(coreIdle, 1'b0)
      repeat (8) @(posedge clk);
      #1 `CHK(ratioCode, 3'h3)
      `CHK(ratioHalves, 4'h7)
      `CHK(strapFault, 1'b1)
      @(posedge clk);
      runRequest <= 1'b0;
      holdReset <= 1'b1;
      freqHigh <= 1'b0;
      repeat (5) @(posedge clk);
      #1 `CHK(pinOutEn, 8'h00)
      `CHK(coreIdle, 1'b1)
      `CHK(inReset, 1'b1)
      boot(3'h2);
      `CHK(ratioHalves, 4'h6)
      repeat (4) @(posedge clk);
      #1 `CHK(strapFault, 1'b1)
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_codes;
      t_run;
      tally_and_finish;
   end
   initial begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
